// ---- eti_pkg.sv ----
// Constants, record layouts and state types of the edge timestamp capture.
package eti_pkg;

  // Clock and the one microsecond time base.
  localparam int          CLK_FREQ_HZ  = 25_000_000;
  localparam int          HZ_PER_MHZ   = 1_000_000;
  localparam int          TICK_CYCLES  = CLK_FREQ_HZ / HZ_PER_MHZ;
  localparam logic [4:0]  TICK_LAST    = 5'(TICK_CYCLES - 1);

  // Channel count and record slots of both image variants.
  localparam int          NUM_CH       = 2;
  localparam int          REC_SHORT    = 5;
  localparam int          REC_LONG     = 15;
  localparam logic [7:0]  LEN_SHORT    = 8'h14;
  localparam logic [7:0]  LEN_LONG     = 8'h3C;
  localparam logic [7:0]  OUT_LEN      = 8'h00;

  // Filter delay codes and their delays in microseconds.
  localparam logic [7:0]  DLY_C1       = 8'h00;
  localparam logic [7:0]  DLY_C3       = 8'h02;
  localparam logic [7:0]  DLY_C10      = 8'h04;
  localparam logic [7:0]  DLY_C86      = 8'h07;
  localparam logic [7:0]  DLY_C342     = 8'h09;
  localparam logic [7:0]  DLY_C2731    = 8'h0C;
  localparam logic [11:0] DLY_US1      = 12'h001;
  localparam logic [11:0] DLY_US3      = 12'h003;
  localparam logic [11:0] DLY_US10     = 12'h00A;
  localparam logic [11:0] DLY_US86     = 12'h056;
  localparam logic [11:0] DLY_US342    = 12'h156;
  localparam logic [11:0] DLY_US2731   = 12'hAAB;
  localparam logic [7:0]  DLY_RESET    = 8'h02;
  localparam logic [1:0]  EDGE_RESET   = 2'h0;

  // Record set numbers and object indices.
  localparam logic [15:0] DS_DIAG_HEAD = 16'h0000;
  localparam logic [15:0] DS_DIAG      = 16'h0001;
  localparam logic [15:0] DS_DELAY     = 16'h0001;
  localparam logic [15:0] DS_LEN       = 16'h0002;
  localparam logic [15:0] DS_EDGE      = 16'h0080;
  localparam logic [15:0] IX_PARAM     = 16'h3100;
  localparam logic [15:0] IX_PARAM_END = 16'h3105;
  localparam logic [15:0] IX_DIAG_HEAD = 16'h2F00;
  localparam logic [15:0] IX_DIAG      = 16'h2F01;

  // Parameter items in object index order.
  localparam logic [2:0]  IT_ILEN      = 3'h0;
  localparam logic [2:0]  IT_OLEN      = 3'h1;
  localparam logic [2:0]  IT_DLY0      = 3'h2;
  localparam logic [2:0]  IT_DLY1      = 3'h3;
  localparam logic [2:0]  IT_RISE      = 3'h4;
  localparam logic [2:0]  IT_FALL      = 3'h5;

  // Diagnostic record layout and fixed contents.
  localparam logic [4:0]  DIAG_HEAD_LEN = 5'h04;
  localparam logic [4:0]  DIAG_LEN      = 5'h14;
  localparam logic [4:0]  DG_MODCLASS   = 5'h01;
  localparam logic [4:0]  DG_CHCLASS    = 5'h04;
  localparam logic [4:0]  DG_DIAGBITS   = 5'h05;
  localparam logic [4:0]  DG_CHCOUNT    = 5'h06;
  localparam logic [4:0]  DG_TICKS      = 5'h10;
  localparam logic [7:0]  MODCLASS_VAL  = 8'h1F;
  localparam logic [7:0]  CHCLASS_VAL   = 8'h70;
  localparam logic [7:0]  DIAGBITS_VAL  = 8'h00;
  localparam logic [7:0]  CHCOUNT_VAL   = 8'h02;

  // One image record: input states in byte 0, ticker bits above it.
  typedef struct packed {
    logic [23:0] ticks;
    logic [5:0]  zero;
    logic [1:0]  states;
  } eti_rec_t;

  typedef enum logic [0:0] {
    ACC_IDLE = 1'b0,
    ACC_DONE = 1'b1
  } eti_acc_t;

  // Whole state of the capture block.
  typedef struct packed {
    logic [1:0]                 sync1;
    logic [1:0]                 sync2;
    logic [1:0]                 filt;
    logic [1:0][11:0]           fcnt;
    logic [4:0]                 div;
    logic                       tick;
    logic [1:0][7:0]            dly;
    logic [1:0]                 rise_en;
    logic [1:0]                 fall_en;
    logic                       long_q;
    logic                       pend;
    eti_rec_t                   pend_rec;
    logic                       drop;
    eti_rec_t [REC_LONG-1:0]    img;
    logic [3:0]                 cnt;
    logic [31:0]                diag_ticks;
    eti_acc_t                   acc;
    logic                       ack;
    logic                       err;
    logic [7:0]                 rdata;
    logic [7:0]                 img_data;
  } eti_state_t;

endpackage

// ---- eti_capture.sv ----
// Two channel edge timestamp capture with record FIFO and record access.
//
// Function
// - Image length fixed at 14h or 3Ch only.
// - Output image length always reads zero.
// - Delay codes select six input filter delays.
// - Rising select bits enable rising edge records.
// - Falling select bits enable falling edge records.
// - Enabled edge stores ticker plus input states.
// - New record at offset zero, older shift.
// - Short image keeps five records, oldest dropped.
// - Long image keeps fifteen records likewise.
// - No interrupts; diagnostics read on demand.
// - Diagnostics at set 01h, head at 00h.
// - Diagnostics at index 2F01h, head 2F00h.
// - Diagnostic record byte order as listed.
// - Module class byte reads 1Fh.
// - Diagnostic bits per channel read 00h.
// - Channel count byte reads 02h.
// - Diagnostic ticker sampled when record generated.
`timescale 1ns/1ns

// Record FIFO between edge capture and the shifting image.
module eti_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 32
) (
  input  wire logic             sys_clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wp;
    logic [AW-1:0]               rp;
    logic [AW:0]                 cnt;
  } eti_fifo_st_t;

  eti_fifo_st_t s;
  eti_fifo_st_t n;
  logic         push;
  logic         pop;

  // Handshakes on both sides; full and empty come from the count.
  assign in_ready_o  = s.cnt != (AW+1)'(DEPTH);
  assign out_valid_o = s.cnt != '0;
  assign out_data_o  = s.mem[s.rp];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  // Pointer and storage update.
  always_comb
  begin
    n = s;
    if (push)
    begin
      n.mem[s.wp] = in_data_i;
      n.wp        = (s.wp == AW'(DEPTH - 1)) ? '0 : s.wp + AW'(1);
    end
    if (pop)
    begin
      n.rp = (s.rp == AW'(DEPTH - 1)) ? '0 : s.rp + AW'(1);
    end
    n.cnt = s.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  // State register.
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      s <= '0;
    else
      s <= n;
  end
endmodule

// Capture top: input filters, edge capture, image and record access.
module eti_capture
  import eti_pkg::*;
#(
  parameter int FIFO_DEPTH = 32,
  parameter bit LONG_INIT  = 1'b0
) (
  input  wire logic        sys_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [1:0]  din_i,
  input  wire logic [31:0] ticker_us_i,
  input  wire logic        img_hold_i,
  input  wire logic [5:0]  img_addr_i,
  output logic [7:0]       img_data_o,
  output logic [3:0]       img_count_o,
  output logic [1:0]       input_state_o,
  output logic             capture_drop_o,
  input  wire logic        rec_req_i,
  input  wire logic        rec_wr_i,
  input  wire logic        rec_canopen_i,
  input  wire logic [15:0] rec_id_i,
  input  wire logic [4:0]  rec_byte_i,
  input  wire logic [7:0]  rec_wdata_i,
  output logic             rec_ack_o,
  output logic             rec_err_o,
  output logic [7:0]       rec_rdata_o
);
  eti_state_t s;
  eti_state_t n;
  logic       fifo_in_rdy;
  logic       fifo_out_vld;
  logic       pop;
  eti_rec_t   fifo_dout;

  // Microsecond delay of a filter code; unlisted codes never get stored.
  function automatic logic [11:0] dly_us(input logic [7:0] code);
    case (code)
      DLY_C1:    dly_us = DLY_US1;
      DLY_C3:    dly_us = DLY_US3;
      DLY_C10:   dly_us = DLY_US10;
      DLY_C86:   dly_us = DLY_US86;
      DLY_C342:  dly_us = DLY_US342;
      default:   dly_us = DLY_US2731;
    endcase
  endfunction

  function automatic logic dly_ok(input logic [7:0] code);
    dly_ok = code == DLY_C1 || code == DLY_C3 || code == DLY_C10
          || code == DLY_C86 || code == DLY_C342 || code == DLY_C2731;
  endfunction

  // Diagnostic record byte at an offset; all other bytes are reserved.
  function automatic logic [7:0] diag_byte(input logic [4:0]  ofs,
                                           input logic [31:0] ticks);
    diag_byte = 8'h00;
    if (ofs == DG_MODCLASS)
      diag_byte = MODCLASS_VAL;
    else if (ofs == DG_CHCLASS)
      diag_byte = CHCLASS_VAL;
    else if (ofs == DG_DIAGBITS)
      diag_byte = DIAGBITS_VAL;
    else if (ofs == DG_CHCOUNT)
      diag_byte = CHCOUNT_VAL;
    else if (ofs >= DG_TICKS && ofs < DIAG_LEN)
      diag_byte = ticks[8*(ofs-DG_TICKS) +: 8];
  endfunction

  // Records waiting for the image; draining stalls while the host holds it.
  eti_fifo #(
    .WIDTH ($bits(eti_rec_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .sys_clk_i   (sys_clk_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (s.pend),
    .in_ready_o  (fifo_in_rdy),
    .in_data_i   (s.pend_rec),
    .out_valid_o (fifo_out_vld),
    .out_ready_i (!img_hold_i),
    .out_data_o  (fifo_dout)
  );

  assign pop = fifo_out_vld && !img_hold_i;

  // Next state of the whole block.
  always_comb
  begin
    logic       ev;
    logic       par;
    logic       diag;
    logic [2:0] item;
    int         maxrec;
    int         limit;
    ev     = 1'b0;
    par    = 1'b0;
    diag   = 1'b0;
    item   = IT_ILEN;
    n      = s;
    maxrec = s.long_q ? REC_LONG : REC_SHORT;
    limit  = 4 * maxrec;
    // Pin synchroniser and microsecond divider.
    n.sync1 = din_i;
    n.sync2 = s.sync1;
    n.tick  = 1'b0;
    if (s.div == TICK_LAST)
    begin
      n.div  = '0;
      n.tick = 1'b1;
    end
    else
      n.div = s.div + 5'h01;
    // A new level is taken once it has stood for the coded delay.
    for (int c = 0; c < NUM_CH; c++)
    begin
      if (s.sync2[c] == s.filt[c])
        n.fcnt[c] = '0;
      else if (s.tick)
      begin
        if (s.fcnt[c] + 12'h001 >= dly_us(s.dly[c]))
        begin
          n.filt[c] = s.sync2[c];
          n.fcnt[c] = '0;
          if (s.sync2[c] ? s.rise_en[c] : s.fall_en[c])
            ev = 1'b1;
        end
        else
          n.fcnt[c] = s.fcnt[c] + 12'h001;
      end
    end
    // Capture slot; a new event while the slot is full and the FIFO refuses is dropped.
    n.drop = 1'b0;
    if (s.pend && fifo_in_rdy)
      n.pend = 1'b0;
    if (ev)
    begin
      if (!s.pend || fifo_in_rdy)
      begin
        n.pend            = 1'b1;
        n.pend_rec.ticks  = ticker_us_i[23:0];
        n.pend_rec.zero   = 6'h00;
        n.pend_rec.states = n.filt;
      end
      else
        n.drop = 1'b1;
    end
    // Newest record enters slot zero; the oldest falls off the end.
    if (pop)
    begin
      for (int i = REC_LONG - 1; i > 0; i--)
        n.img[i] = (i < maxrec) ? s.img[i-1] : '0;
      n.img[0] = fifo_dout;
      if (s.cnt < 4'(maxrec))
        n.cnt = s.cnt + 4'h1;
    end
    // Image byte read, zero beyond the configured length.
    n.img_data = 8'h00;
    if (int'(img_addr_i) < limit)
      n.img_data = s.img[img_addr_i[5:2]][8*img_addr_i[1:0] +: 8];
    // Record access: decode the request into a parameter or diagnostics.
    n.ack = 1'b0;
    n.err = 1'b0;
    if (rec_canopen_i)
    begin
      if (rec_id_i >= IX_PARAM && rec_id_i <= IX_PARAM_END
          && rec_byte_i == 5'h00)
      begin
        par  = 1'b1;
        item = 3'(rec_id_i - IX_PARAM);
      end
      else if (rec_id_i == IX_DIAG && rec_byte_i < DIAG_LEN)
        diag = 1'b1;
      else if (rec_id_i == IX_DIAG_HEAD && rec_byte_i < DIAG_HEAD_LEN)
        diag = 1'b1;
    end
    else if (rec_id_i == DS_LEN && rec_byte_i < 5'h02)
    begin
      par  = 1'b1;
      item = rec_byte_i[0] ? IT_OLEN : IT_ILEN;
    end
    else if (rec_id_i == DS_EDGE && rec_byte_i < 5'h02)
    begin
      par  = 1'b1;
      item = rec_byte_i[0] ? IT_FALL : IT_RISE;
    end
    else if (rec_wr_i && rec_id_i == DS_DELAY && rec_byte_i < 5'h02)
    begin
      par  = 1'b1;
      item = rec_byte_i[0] ? IT_DLY1 : IT_DLY0;
    end
    else if (!rec_wr_i && rec_id_i == DS_DIAG && rec_byte_i < DIAG_LEN)
      diag = 1'b1;
    else if (!rec_wr_i && rec_id_i == DS_DIAG_HEAD
             && rec_byte_i < DIAG_HEAD_LEN)
      diag = 1'b1;
    case (s.acc)
      ACC_IDLE:
      begin
        if (rec_req_i)
        begin
          n.acc   = ACC_DONE;
          n.ack   = 1'b1;
          n.rdata = 8'h00;
          if (diag)
          begin
            if (rec_wr_i)
              n.err = 1'b1;
            else if (rec_byte_i == 5'h00)
            begin
              n.diag_ticks = ticker_us_i;
              n.rdata      = diag_byte(rec_byte_i, ticker_us_i);
            end
            else
              n.rdata = diag_byte(rec_byte_i, s.diag_ticks);
          end
          else if (!par)
            n.err = 1'b1;
          else if (!rec_wr_i)
          begin
            case (item)
              IT_ILEN: n.rdata = s.long_q ? LEN_LONG : LEN_SHORT;
              IT_OLEN: n.rdata = OUT_LEN;
              IT_DLY0: n.rdata = s.dly[0];
              IT_DLY1: n.rdata = s.dly[1];
              IT_RISE: n.rdata = {6'h00, s.rise_en};
              default: n.rdata = {6'h00, s.fall_en};
            endcase
          end
          else
          begin
            case (item)
              IT_ILEN:
              begin
                // Lengths arrive only while stopped, so the image restarts.
                if (rec_wdata_i == LEN_SHORT || rec_wdata_i == LEN_LONG)
                begin
                  n.long_q = rec_wdata_i == LEN_LONG;
                  n.img    = '0;
                  n.cnt    = '0;
                end
                else
                  n.err = 1'b1;
              end
              IT_OLEN: n.err = rec_wdata_i != OUT_LEN;
              IT_DLY0, IT_DLY1:
              begin
                if (dly_ok(rec_wdata_i))
                  n.dly[item[0]] = rec_wdata_i;
                else
                  n.err = 1'b1;
              end
              IT_RISE: n.rise_en = rec_wdata_i[1:0];
              default: n.fall_en = rec_wdata_i[1:0];
            endcase
          end
        end
      end
      ACC_DONE:
        n.acc = ACC_IDLE;
      default:
        n.acc = ACC_IDLE;
    endcase
  end

  // State register with documented parameter defaults.
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      s         <= '0;
      s.dly     <= {DLY_RESET, DLY_RESET};
      s.rise_en <= EDGE_RESET;
      s.fall_en <= EDGE_RESET;
      s.long_q  <= LONG_INIT;
      s.acc     <= ACC_IDLE;
    end
    else
      s <= n;
  end

  // Outputs straight from the state register; no interrupt output exists.
  assign img_data_o     = s.img_data;
  assign img_count_o    = s.cnt;
  assign input_state_o  = s.filt;
  assign capture_drop_o = s.drop;
  assign rec_ack_o      = s.ack;
  assign rec_err_o      = s.err;
  assign rec_rdata_o    = s.rdata;

  // Checks on the capture path and the record access.
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  filt_on_tick_a: assert property (
    $changed(s.filt) |-> $past(s.tick))
    else $error("Filter output moved without a microsecond tick.");

  filt_delay_a: assert property (
    $changed(s.filt[0]) |->
      $past(s.fcnt[0]) + 12'h001 >= dly_us($past(s.dly[0])))
    else $error("Filter accepted a level before its delay.");

  rise_capture_a: assert property (
    $rose(s.filt[0]) && $past(s.rise_en[0]) && !$past(s.pend)
      |-> s.pend && s.pend_rec.states[0]
          && s.pend_rec.ticks == $past(ticker_us_i[23:0]))
    else $error("Enabled rising edge was not captured.");

  fall_capture_a: assert property (
    $fell(s.filt[1]) && $past(s.fall_en[1]) && !$past(s.pend)
      |-> s.pend && !s.pend_rec.states[1])
    else $error("Enabled falling edge was not captured.");

  no_capture_a: assert property (
    $changed(s.filt) && !$past(s.pend)
      && $past(s.rise_en) == 2'h0 && $past(s.fall_en) == 2'h0
      |-> !s.pend)
    else $error("Record captured with no edge enabled.");

  image_shift_a: assert property (
    pop && !(s.acc == ACC_IDLE && rec_req_i && rec_wr_i)
      |=> s.img[0] == $past(fifo_dout) && s.img[1] == $past(s.img[0]))
    else $error("Image did not shift in the new record.");

  record_limit_a: assert property (
    s.cnt <= (s.long_q ? 4'(REC_LONG) : 4'(REC_SHORT))
      && (s.long_q || s.img[REC_SHORT] == '0))
    else $error("Image holds more records than its variant.");

  length_read_a: assert property (
    s.acc == ACC_IDLE && rec_req_i && !rec_wr_i && !rec_canopen_i
      && rec_id_i == DS_LEN && rec_byte_i == 5'h00
      |=> rec_ack_o && (rec_rdata_o == LEN_SHORT || rec_rdata_o == LEN_LONG)
          ##1 !rec_ack_o)
    else $error("Input image length read back wrong.");

  out_len_a: assert property (
    s.acc == ACC_IDLE && rec_req_i && !rec_wr_i && rec_canopen_i
      && rec_id_i == IX_PARAM + 16'h0001 && rec_byte_i == 5'h00
      |=> rec_ack_o && rec_rdata_o == OUT_LEN && !rec_err_o)
    else $error("Output image length not zero.");

  diag_class_a: assert property (
    s.acc == ACC_IDLE && rec_req_i && !rec_wr_i && !rec_canopen_i
      && rec_id_i == DS_DIAG && rec_byte_i == DG_MODCLASS
      |=> rec_rdata_o == MODCLASS_VAL)
    else $error("Module class byte read wrong.");

  diag_write_a: assert property (
    s.acc == ACC_IDLE && rec_req_i && rec_wr_i && rec_canopen_i
      && rec_id_i == IX_DIAG && rec_byte_i < DIAG_LEN
      |=> rec_ack_o && rec_err_o)
    else $error("Diagnostic write was not refused.");

  cover_capture_c: cover property (pop);
  cover_full_c:    cover property (pop && s.cnt == 4'(REC_SHORT));
  cover_drop_c:    cover property (s.drop);
  cover_diag_c:    cover property (rec_ack_o && s.acc == ACC_DONE
                                   && !rec_err_o);
endmodule

// ---- eti_head_model.sv ----
// Head module model: free-running microsecond ticker.
`timescale 1ns/1ns
module eti_head_model
  import eti_pkg::*;
(
  input  wire logic  sys_clk_i,
  input  wire logic  rst_n_i,
  output logic [31:0] ticker_us_o
);
  logic [4:0] div_q;

  // Advances the ticker once every microsecond of clock.
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      div_q       <= 5'h00;
      ticker_us_o <= 32'hFFFF_F000;
    end
    else if (div_q == TICK_LAST)
    begin
      div_q       <= 5'h00;
      ticker_us_o <= ticker_us_o + 32'h1;
    end
    else
    begin
      div_q <= div_q + 5'h01;
    end
  end
endmodule

// ---- edge_timestamp_input_capture_tb.sv ----
// Self-checking bench of the edge timestamp capture.
`timescale 1ns/1ns
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin num_errors++; \
  $display("BAD %0t got %0h exp %0h", $time, a, b); end end
module edge_timestamp_input_capture_tb;
  import eti_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        hold = 1'b0;
  logic        req = 1'b0;
  logic        wr = 1'b0;
  logic        co = 1'b0;
  logic [1:0]  din = 2'h0;
  logic [5:0]  addr = 6'h00;
  logic [15:0] id = 16'h0000;
  logic [4:0]  bsel = 5'h00;
  logic [7:0]  wd = 8'h00;
  logic [31:0] tick;
  logic [7:0]  idata;
  logic [7:0]  rdata;
  logic [3:0]  cnt;
  logic [1:0]  st;
  logic        drop;
  logic        ack;
  logic        err;
  logic [1:0]  rse;
  logic [1:0]  fse;
  logic [1:0]  sts[$];
  logic [23:0] tedge[$];
  int          num_errors = 0;
  int          comparisons = 0;

  eti_capture eti_capture_inst (.sys_clk_i(clk), .rst_n_i(rst_n),
    .din_i(din), .ticker_us_i(tick), .img_hold_i(hold),
    .img_addr_i(addr), .img_data_o(idata), .img_count_o(cnt),
    .input_state_o(st), .capture_drop_o(drop), .rec_req_i(req),
    .rec_wr_i(wr), .rec_canopen_i(co), .rec_id_i(id),
    .rec_byte_i(bsel), .rec_wdata_i(wd), .rec_ack_o(ack),
    .rec_err_o(err), .rec_rdata_o(rdata));
  eti_head_model eti_head_model_inst (.sys_clk_i(clk), .rst_n_i(rst_n),
    .ticker_us_o(tick));

  // Clock of 40 ns period.
  always #20 clk = ~clk;

  // One record access, held until the answer is seen.
  task automatic acc(input logic w, input logic c, input logic [15:0] i,
                     input logic [4:0] b, input logic [7:0] d,
                     input logic e);
    int n;
    n = 0;
    @(posedge clk);
    req  <= 1'b1;
    wr   <= w;
    co   <= c;
    id   <= i;
    bsel <= b;
    wd   <= d;
    do
    begin
      @(negedge clk);
      n++;
    end
    while (ack !== 1'b1 && n < 8);
    `CHK(ack, 1'b1)
    `CHK(err, e)
    @(posedge clk);
    req <= 1'b0;
  endtask

  // Reads one image byte.
  task automatic img(input int a, output logic [7:0] v);
    @(posedge clk);
    addr <= 6'(a);
    @(negedge clk);
    @(negedge clk);
    v = idata;
  endtask

  // Toggles one input and notes the record it should make.
  task automatic ev(input int c, input logic h);
    logic [1:0] nd;
    nd = din;
    nd[c] = ~nd[c];
    @(posedge clk);
    din  <= nd;
    hold <= h;
    if (nd[c] ? rse[c] : fse[c])
    begin
      sts.push_front(nd);
      tedge.push_front(tick[23:0]);
    end
    repeat (100) @(posedge clk);
    @(negedge clk);
    `CHK(st, nd)
    `CHK(drop, 1'b0)
  endtask

  // Compares the image with the noted records.
  task automatic chk_img(input int mx);
    int n;
    logic [7:0] v;
    logic [23:0] t;
    n = (sts.size() < mx) ? sts.size() : mx;
    `CHK(cnt, 4'(n))
    for (int k = 0; k < n; k++)
    begin
      img(4 * k, v);
      `CHK(v, {6'h00, sts[k]})
      for (int j = 1; j < 4; j++)
      begin
        img(4 * k + j, v);
        t[8*(j-1)+:8] = v;
      end
      `CHK(24'(t - tedge[k]) <= 24'h000004, 1'b1)
    end
    img(4 * n, v);
    `CHK(v, 8'h00)
  endtask

  // Expected fixed diagnostic byte.
  function automatic logic [7:0] dexp(input int b);
    case (b)
      1: return 8'h1F;
      4: return 8'h70;
      6: return 8'h02;
      default: return 8'h00;
    endcase
  endfunction

  // Prints the counts and the verdict.
  task automatic end_of_test();
    $display("comparisons %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Cuts a hang short.
  initial
  begin
    #400000;
    num_errors++;
    end_of_test();
  end

  // Main sequence.
  initial
  begin
    logic [7:0] codes[6];
    logic [31:0] t0;
    logic [31:0] snap;
    logic [15:0] sid;
    int len;
    codes = '{8'h0C, 8'h09, 8'h07, 8'h04, 8'h02, 8'h00};
    void'($urandom(19));
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    acc(0, 0, 16'h0002, 0, 0, 0);
    `CHK(rdata, 8'h14)
    acc(0, 0, 16'h0002, 1, 0, 0);
    `CHK(rdata, 8'h00)
    acc(0, 1, 16'h3102, 0, 0, 0);
    `CHK(rdata, 8'h02)
    acc(1, 0, 16'h0002, 0, 8'h20, 1);
    acc(1, 0, 16'h0002, 1, 8'h01, 1);
    acc(1, 0, 16'h0001, 0, 8'h01, 1);
    acc(1, 1, 16'h2F01, 1, 8'h55, 1);
    acc(0, 0, 16'h0055, 0, 0, 1);
    for (int i = 0; i < 6; i++)
    begin
      acc(1, 0, 16'h0001, 5'(i % 2), codes[i], 0);
      acc(0, 1, 16'h3102 + 16'(i % 2), 0, 0, 0);
      `CHK(rdata, codes[i])
    end
    acc(1, 1, 16'h3102, 0, 8'h00, 0);
    $display("done: access and refusals");
    for (int s = 0; s < 4; s++)
    begin
      sid = (s < 2) ? 16'(s) : 16'h2F00 + 16'(s - 2);
      len = (s % 2) ? 20 : 4;
      t0 = tick;
      for (int b = 0; b < len; b++)
      begin
        acc(0, s >= 2, sid, 5'(b), 0, 0);
        if (b < 16)
          `CHK(rdata, dexp(b))
        else
          snap[8*(b-16)+:8] = rdata;
      end
      if (len == 20)
        `CHK(snap - t0 <= 32'h1, 1'b1)
      else
        acc(0, s >= 2, sid, 5'h04, 0, 1);
    end
    $display("done: diagnostics");
    rse = 2'($urandom_range(0, 3));
    fse = 2'($urandom_range(0, 3));
    acc(1, 0, 16'h0080, 0, 8'hFC | {6'h00, rse}, 0);
    acc(1, 1, 16'h3105, 0, 8'hFC | {6'h00, fse}, 0);
    acc(0, 0, 16'h0080, 0, 0, 0);
    `CHK(rdata, {6'h00, rse})
    acc(0, 0, 16'h0080, 1, 0, 0);
    `CHK(rdata, {6'h00, fse})
    for (int i = 0; i < 12; i++)
      ev($urandom_range(0, 1), i < 3);
    chk_img(5);
    $display("done: short image");
    acc(1, 0, 16'h0002, 0, 8'h3C, 0);
    `CHK(cnt, 4'h0)
    sts.delete();
    tedge.delete();
    rse = 2'h3;
    fse = 2'h3;
    acc(1, 0, 16'h0080, 0, 8'h03, 0);
    acc(1, 0, 16'h0080, 1, 8'h03, 0);
    for (int i = 0; i < 17; i++)
      ev(i % 2, 1'b0);
    chk_img(15);
    acc(0, 1, 16'h3100, 0, 0, 0);
    `CHK(rdata, 8'h3C)
    $display("done: long image");
    end_of_test();
  end
endmodule
